//--- hdl/qsis_thr_cmp.sv
// threshold comparator: registered "more free words than threshold" per buffer
`timescale 1ns/10ps
module qsis_thr_cmp
   import qsis_pkg::*;
#(
   parameter int W = 8
) (
   input wire logic   pclk,
   input wire logic   presetn,
   input wire logic   ce,
   qsis_cmp_if.cmp    cmp
);
   typedef struct packed {
      logic [2:0] above;
   } qsis_cmp_st_t;

   qsis_cmp_st_t s_q;
   qsis_cmp_st_t s_d;

   function automatic logic qsis_gt(input logic [W-1:0] free, input logic [W-1:0] thr);
      qsis_gt = free > thr;
   endfunction

   always_comb begin
      s_d          = s_q;
      s_d.above[0] = qsis_gt(cmp.tx_free, cmp.tx_thr);
      s_d.above[1] = qsis_gt(cmp.rx_free, cmp.rx_thr);
      s_d.above[2] = qsis_gt(cmp.con_free, cmp.con_thr);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   assign cmp.above = s_q.above;
endmodule

//--- hdl/qsis_top.sv
// top: interrupt status flags with write-one-to-clear over APB
//
// Operation
// - packet-completion flag, bit 10, set when descriptor engine finishes a packet.
// - descriptor-done flag, bit 9, set when the descriptor process finishes.
// - control-threshold flag, bit 8, set when control free space exceeds threshold.
// - control-empty flag, bit 7, set while the control buffer is empty.
// - control-full flag, bit 6, set while the control buffer is full.
// - receive-threshold flag, bit 5, set when receive free space exceeds threshold.
// - receive-full flag, bit 4, set while the receive buffer is full.
// - receive-empty flag, bit 3, set while the receive buffer is empty.
// - transmit-threshold flag, bit 2, set when transmit free space exceeds threshold.
// - hardware sets flags; writing one clears; writing zero leaves unchanged.
// - boot mode: receive-threshold flag reads one after reset until first system read request.
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/10ps
module qsis_top
   import qsis_pkg::*;
#(
   parameter int W = 8
) (
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          ce,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [11:0]   paddr,
   input  wire logic [31:0]   pwdata,
   output logic      [31:0]   prdata,
   output logic               pready,
   output logic               pslverr,
   input  wire logic [W-1:0]  tx_free,
   input  wire logic          tx_full,
   input  wire logic          tx_empty,
   input  wire logic [W-1:0]  rx_free,
   input  wire logic          rx_full,
   input  wire logic          rx_empty,
   input  wire logic [W-1:0]  con_free,
   input  wire logic          con_full,
   input  wire logic          con_empty,
   input  wire logic          pkt_done,
   input  wire logic          desc_done,
   input  wire logic          sys_read_req,
   output logic      [10:0]   status_flags
);
   typedef struct packed {
      logic [10:0]  flags;
      logic [W-1:0] tx_thr;
      logic [W-1:0] rx_thr;
      logic [W-1:0] con_thr;
      logic         boot_mode;
      logic         boot_hold;
      logic [31:0]  rdata;
      logic         slverr;
   } qsis_st_t;

   qsis_st_t s_q;
   qsis_st_t s_d;

   qsis_cmp_if #(.W(W)) cmp_bus ();

   qsis_thr_cmp #(.W(W)) u_cmp (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .cmp     (cmp_bus.cmp)
   );

   assign cmp_bus.tx_free  = tx_free;
   assign cmp_bus.rx_free  = rx_free;
   assign cmp_bus.con_free = con_free;
   assign cmp_bus.tx_thr   = s_q.tx_thr;
   assign cmp_bus.rx_thr   = s_q.rx_thr;
   assign cmp_bus.con_thr  = s_q.con_thr;

   function automatic logic qsis_hit(input logic [11:0] a, input logic [11:0] ofs);
      qsis_hit = a == ofs;
   endfunction

   logic        acc;
   logic        wr;
   logic        setup;
   logic        mapped;
   logic [10:0] hw_set;
   logic [10:0] sw_clr;
   logic [31:0] thr_word;
   logic [31:0] lvl_word;

   assign acc    = psel & penable & ce;
   assign wr     = acc & pwrite;
   assign setup  = psel & ~penable & ce;
   assign mapped = qsis_hit(paddr, QSIS_STATUS_OFS) | qsis_hit(paddr, QSIS_THRESH_OFS) |
                   qsis_hit(paddr, QSIS_LEVEL_OFS) | qsis_hit(paddr, QSIS_MODE_OFS);

   always_comb begin
      hw_set                     = '0;
      hw_set[QSIS_PKT_DONE_BIT]  = pkt_done;
      hw_set[QSIS_DESC_DONE_BIT] = desc_done;
      hw_set[QSIS_CON_THR_BIT]   = cmp_bus.above[2];
      hw_set[QSIS_CON_EMPTY_BIT] = con_empty;
      hw_set[QSIS_CON_FULL_BIT]  = con_full;
      hw_set[QSIS_RX_THR_BIT]    = cmp_bus.above[1] | s_q.boot_hold;
      hw_set[QSIS_RX_FULL_BIT]   = rx_full;
      hw_set[QSIS_RX_EMPTY_BIT]  = rx_empty;
      hw_set[QSIS_TX_THR_BIT]    = cmp_bus.above[0];
      hw_set[QSIS_TX_FULL_BIT]   = tx_full;
      hw_set[QSIS_TX_EMPTY_BIT]  = tx_empty;
   end

   assign sw_clr = (wr && qsis_hit(paddr, QSIS_STATUS_OFS)) ? pwdata[10:0] : 11'h000;

   always_comb begin
      thr_word = '0;
      thr_word[QSIS_TX_THR_POS +: W]  = s_q.tx_thr;
      thr_word[QSIS_RX_THR_POS +: W]  = s_q.rx_thr;
      thr_word[QSIS_CON_THR_POS +: W] = s_q.con_thr;
      lvl_word = '0;
      lvl_word[QSIS_TX_THR_POS +: W]  = tx_free;
      lvl_word[QSIS_RX_THR_POS +: W]  = rx_free;
      lvl_word[QSIS_CON_THR_POS +: W] = con_free;
   end

   always_comb begin
      s_d        = s_q;
      s_d.slverr = 1'b0;
      // set wins over a same-cycle clear
      s_d.flags  = (s_q.flags & ~sw_clr) | hw_set;
      // boot hold ends on first system read request
      if (sys_read_req) begin
         s_d.boot_hold = 1'b0;
      end
      if (wr && mapped) begin
         if (qsis_hit(paddr, QSIS_THRESH_OFS)) begin
            s_d.tx_thr  = pwdata[QSIS_TX_THR_POS +: W];
            s_d.rx_thr  = pwdata[QSIS_RX_THR_POS +: W];
            s_d.con_thr = pwdata[QSIS_CON_THR_POS +: W];
         end
         if (qsis_hit(paddr, QSIS_MODE_OFS)) begin
            s_d.boot_mode = pwdata[0];
            if (!pwdata[0]) begin
               s_d.boot_hold = 1'b0;
            end
         end
      end
      // read data captured in setup so it stands at the access edge
      if (setup && !pwrite) begin
         case (1'b1)
            qsis_hit(paddr, QSIS_STATUS_OFS): s_d.rdata = {21'h00000, s_q.flags};
            qsis_hit(paddr, QSIS_THRESH_OFS): s_d.rdata = thr_word;
            qsis_hit(paddr, QSIS_LEVEL_OFS):  s_d.rdata = lvl_word;
            qsis_hit(paddr, QSIS_MODE_OFS):   s_d.rdata = {31'h0000000, s_q.boot_mode};
            default:                          s_d.rdata = 32'h0000_0000;
         endcase
      end
      // error flagged in setup, high through the access phase only
      if (setup && !mapped) begin
         s_d.slverr = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q.flags     <= QSIS_STATUS_RST;
         s_q.tx_thr    <= QSIS_THR_RST[W-1:0];
         s_q.rx_thr    <= QSIS_THR_RST[W-1:0];
         s_q.con_thr   <= QSIS_THR_RST[W-1:0];
         s_q.boot_mode <= QSIS_BOOT_MODE_RST[0];
         s_q.boot_hold <= QSIS_BOOT_MODE_RST[0];
         s_q.rdata     <= 32'h0000_0000;
         s_q.slverr    <= 1'b0;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   // zero-wait access phase; read data and error registered in setup, valid in access
   assign pready       = 1'b1;
   assign prdata       = s_q.rdata;
   assign pslverr      = s_q.slverr;
   assign status_flags = s_q.flags;
endmodule

//--- inc/qsis_cmp_if.sv
// interface: free-space comparison request and answer between top and comparator
`timescale 1ns/10ps
interface qsis_cmp_if #(parameter int W = 8);
   logic [W-1:0] tx_free;
   logic [W-1:0] rx_free;
   logic [W-1:0] con_free;
   logic [W-1:0] tx_thr;
   logic [W-1:0] rx_thr;
   logic [W-1:0] con_thr;
   logic [2:0]   above;
   modport top (output tx_free, output rx_free, output con_free,
                output tx_thr, output rx_thr, output con_thr, input above);
   modport cmp (input tx_free, input rx_free, input con_free,
                input tx_thr, input rx_thr, input con_thr, output above);
endinterface

//--- inc/qsis_pkg.sv
// package: offsets, field positions, reset values for the interrupt status block
package qsis_pkg;
   localparam int          QSIS_NFLAG           = 11;
   localparam logic [11:0] QSIS_STATUS_OFS      = 12'h000;
   localparam logic [11:0] QSIS_THRESH_OFS      = 12'h004;
   localparam logic [11:0] QSIS_LEVEL_OFS       = 12'h008;
   localparam logic [11:0] QSIS_MODE_OFS        = 12'h00C;
   localparam int          QSIS_TX_EMPTY_BIT    = 0;
   localparam int          QSIS_TX_FULL_BIT     = 1;
   localparam int          QSIS_TX_THR_BIT      = 2;
   localparam int          QSIS_RX_EMPTY_BIT    = 3;
   localparam int          QSIS_RX_FULL_BIT     = 4;
   localparam int          QSIS_RX_THR_BIT      = 5;
   localparam int          QSIS_CON_FULL_BIT    = 6;
   localparam int          QSIS_CON_EMPTY_BIT   = 7;
   localparam int          QSIS_CON_THR_BIT     = 8;
   localparam int          QSIS_DESC_DONE_BIT   = 9;
   localparam int          QSIS_PKT_DONE_BIT    = 10;
   localparam int          QSIS_TX_THR_POS      = 0;
   localparam int          QSIS_RX_THR_POS      = 8;
   localparam int          QSIS_CON_THR_POS     = 16;
   localparam logic [10:0] QSIS_STATUS_RST      = 11'h0AD;
   localparam logic [7:0]  QSIS_THR_RST         = 8'h00;
   localparam logic [31:0] QSIS_BOOT_MODE_RST   = 32'h0000_0001;
   typedef enum logic [1:0] {
      QSIS_IDLE   = 2'b00,
      QSIS_ACCESS = 2'b01
   } qsis_bus_t;
endpackage

//--- test/qsis_sva.sv
// checker: interrupt status flag and bus response assertions
`timescale 1ns/10ps
module qsis_sva
   import qsis_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        ce,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   input wire logic        tx_full,
   input wire logic        pkt_done,
   input wire logic        desc_done,
   input wire logic        sys_read_req,
   input wire logic [10:0] status_flags
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic acc = psel && penable && ce;
   wire logic wst = acc && pwrite && paddr == QSIS_STATUS_OFS;
   sequence s_clr;
      wst && pwdata[QSIS_PKT_DONE_BIT] && !pkt_done;
   endsequence
   rst_value_a: assert property ($rose(presetn) |-> status_flags == QSIS_STATUS_RST)
      else $error("status not at reset value");
   boot_hold_a: assert property ($rose(presetn) ##0 (!sys_read_req)[*4]
      |-> status_flags[QSIS_RX_THR_BIT]) else $error("boot hold lost");
   tx_full_a: assert property ((ce && tx_full)[*3] |-> status_flags[QSIS_TX_FULL_BIT])
      else $error("full flag missing");
   desc_done_a: assert property (desc_done && ce |=> status_flags[QSIS_DESC_DONE_BIT])
      else $error("done flag missing");
   pkt_clr_a: assert property (s_clr ##1 (!pkt_done)[*2] |-> !status_flags[QSIS_PKT_DONE_BIT])
      else $error("flag not cleared");
   zero_keep_a: assert property (wst && !pwdata[9] && status_flags[9] |=> status_flags[9])
      else $error("flag lost on zero write");
   err_resp_a: assert property (acc && paddr == 12'h010 |-> pslverr)
      else $error("no error response");
   read_data_a: assert property (acc && !pwrite && paddr == QSIS_STATUS_OFS
      |-> prdata == {21'h00000, $past(status_flags)}) else $error("read data differs");
endmodule
bind qsis_top qsis_sva sva_u (.*);

//--- test/qsis_top_tb.sv
// testbench: interrupt status flags over APB
`timescale 1ns/10ps
module qsis_top_tb
   import qsis_pkg::*;
;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic        pkt = 0, dd = 0, srr = 0, pready, pslverr, sl;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, q;
   logic [7:0]  txf = 8'h10, rxf = 8'h10, cof = 8'h00;
   logic [5:0]  lv = 6'h25;
   logic [10:0] sf;
   int          bp[6] = '{0, 1, 3, 4, 6, 7};
   int          error_cnt = 0, checked = 0;
   always #25 pclk = ~pclk;
   qsis_top dut_u (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .tx_free(txf), .tx_empty(lv[0]), .tx_full(lv[1]),
      .rx_free(rxf), .rx_empty(lv[2]), .rx_full(lv[3]), .con_free(cof), .con_full(lv[4]),
      .con_empty(lv[5]), .pkt_done(pkt), .desc_done(dd), .sys_read_req(srr), .status_flags(sf));
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         error_cnt++;
         $display("wrong value %s exp %h seen %h", n, e, s);
      end
   endtask
   task automatic end_sim();
      $display("checked %0d error_cnt %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      q = prdata;
      sl = pslverr;
      psel <= 0;
      penable <= 0;
      if (pready !== 1'b1) begin
         error_cnt++;
         end_sim();
      end else begin
         @(posedge pclk);
      end
   endtask
   task automatic clr_all();
      apb(1, QSIS_STATUS_OFS, 32'h7FF);
      repeat (3) @(posedge pclk);
   endtask
   task automatic t_reset();
      chk("flags", 32'(sf), 32'h0AD);
      apb(0, QSIS_STATUS_OFS, 0);
      chk("status", q, 32'h0AD);
      $display("reset test done");
   endtask
   task automatic t_boot();
      rxf <= 0;
      repeat (3) @(posedge pclk);
      apb(1, QSIS_STATUS_OFS, 32'h20);
      repeat (3) @(posedge pclk);
      chk("boot hold", 32'(sf[5]), 1);
      srr <= 1;
      @(posedge pclk);
      srr <= 0;
      apb(1, QSIS_STATUS_OFS, 32'h20);
      repeat (3) @(posedge pclk);
      chk("boot end", 32'(sf[5]), 0);
      $display("boot test done");
   endtask
   task automatic t_levels();
      lv <= 0;
      txf <= 0;
      repeat (3) @(posedge pclk);
      clr_all();
      chk("cleared", 32'(sf), 0);
      for (int i = 0; i < 6; i++) begin
         lv <= 6'h01 << i;
         repeat (3) @(posedge pclk);
         lv <= 0;
         apb(1, QSIS_STATUS_OFS, 0);
         repeat (2) @(posedge pclk);
         chk("level", 32'(sf), 32'h1 << bp[i]);
         apb(1, QSIS_STATUS_OFS, 32'h1 << bp[i]);
         repeat (2) @(posedge pclk);
         chk("level clr", 32'(sf), 0);
      end
      $display("level test done");
   endtask
   task automatic t_thresh();
      apb(1, QSIS_THRESH_OFS, 32'h0005_0505);
      apb(0, QSIS_THRESH_OFS, 0);
      chk("thresholds", q, 32'h0005_0505);
      {txf, rxf, cof} <= {3{8'h05}};
      repeat (4) @(posedge pclk);
      clr_all();
      chk("at threshold", 32'(sf), 0);
      {txf, rxf, cof} <= {3{8'h06}};
      repeat (4) @(posedge pclk);
      chk("above", 32'(sf), 32'h124);
      {txf, rxf, cof} <= {3{8'h05}};
      repeat (3) @(posedge pclk);
      clr_all();
      $display("threshold test done");
   endtask
   task automatic t_events();
      chk("idle", 32'(sf), 0);
      dd <= 1;
      @(posedge pclk);
      dd <= 0;
      repeat (3) @(posedge pclk);
      apb(1, QSIS_STATUS_OFS, 0);
      repeat (2) @(posedge pclk);
      chk("done", 32'(sf), 32'h200);
      pkt <= 1;
      @(posedge pclk);
      pkt <= 0;
      repeat (3) @(posedge pclk);
      chk("packet", 32'(sf), 32'h600);
      apb(1, QSIS_STATUS_OFS, 32'h400);
      repeat (2) @(posedge pclk);
      chk("one clr", 32'(sf), 32'h200);
      apb(1, 12'h010, 32'h200);
      chk("unmapped", {31'h0, sl}, 1);
      apb(0, QSIS_STATUS_OFS, 0);
      chk("rd flags", q, 32'h200);
      $display("event test done");
   endtask
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      t_reset();
      t_boot();
      t_levels();
      t_thresh();
      t_events();
      end_sim();
   end
endmodule
